// [hdl/ifo_top.sv]
`timescale 1ns/1ps
`include "ifo_defines.svh"
// ****************************************
// Input frame offset block, streams 8-15
// ****************************************
module ifo_top #(
  parameter int NSTR = 8
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link pins
  input  wire logic        link_clk,
  input  wire logic        frame_pulse_in,
  input  wire logic [NSTR-1:0] serial_stream_in,
  // Received bits
  output logic [NSTR-1:0]  rx_valid,
  output logic [NSTR-1:0]  rx_data,
  output logic [NSTR-1:0]  rx_frame_start
);
  typedef struct packed {
    logic [15:0]     ofs_lo;
    logic [15:0]     ofs_hi;
    logic [31:0]     act;
    logic            gci;
    logic [31:0]     rdata;
    logic            ready;
    logic            err;
    logic [2:0]      clk_s;
    logic [1:0]      fp_s;
    logic            fp_d;
    logic [2*NSTR-1:0] st_s;
    logic [NSTR-1:0] v;
    logic [NSTR-1:0] d;
    logic [NSTR-1:0] f;
    logic [15:0]     frames;
  } ifo_top_st_t;

  ifo_top_st_t s_reg;
  ifo_top_st_t s_next;
  logic        rise_evt;
  logic        fall_evt;
  logic        frame_evt;
  logic        acc;
  logic [NSTR-1:0] lv;
  logic [NSTR-1:0] ld;
  logic [NSTR-1:0] lf;
  logic [15:0] meas;
  logic [2*NSTR-1:0] st_now;

  // Edge finding on synchronised link clock, frame pulse active low
  always_comb begin
    rise_evt  = s_reg.clk_s[1] & ~s_reg.clk_s[2];
    fall_evt  = ~s_reg.clk_s[1] & s_reg.clk_s[2];
    frame_evt = ~s_reg.fp_s[1] & s_reg.fp_d;
    acc       = psel & penable & ~s_reg.ready;
  end

  // Stream data second stage
  generate
    for (genvar i = 0; i < NSTR; i++) begin : g_st
      assign st_now[i] = s_reg.st_s[NSTR+i];
    end
  endgenerate

  // Measurement view of stream 8 config (half flag, delay bits)
  always_comb begin
    meas      = 16'h0000;
    meas[11]  = ~s_reg.act[`IFO_EDGE_BIT];
    meas[2:0] = s_reg.act[3:1];
  end

  // Bus, sync and config next state
  always_comb begin
    s_next       = s_reg;
    s_next.clk_s = {s_reg.clk_s[1:0], link_clk};
    s_next.fp_s  = {s_reg.fp_s[0], frame_pulse_in};
    s_next.fp_d  = s_reg.fp_s[1];
    s_next.st_s  = {s_reg.st_s[NSTR-1:0], serial_stream_in};
    s_next.v     = lv;
    s_next.d     = ld;
    s_next.f     = lf;
    s_next.ready = acc;
    s_next.err   = 1'b0;
    if (frame_evt) begin
      s_next.act    = {s_reg.ofs_hi, s_reg.ofs_lo};
      s_next.frames = s_reg.frames + 16'h0001;
    end
    if (acc) begin
      s_next.rdata = 32'h0000_0000;
      case (paddr)
        `IFO_ADDR_OFS_LO: begin
          s_next.rdata = {16'h0000, s_reg.ofs_lo};
          if (pwrite) begin
            s_next.ofs_lo = pwdata[15:0];
          end
        end
        `IFO_ADDR_OFS_HI: begin
          s_next.rdata = {16'h0000, s_reg.ofs_hi};
          if (pwrite) begin
            s_next.ofs_hi = pwdata[15:0];
          end
        end
        `IFO_ADDR_CTRL: begin
          s_next.rdata = {31'h0, s_reg.gci};
          if (pwrite) begin
            s_next.gci = pwdata[`IFO_CTRL_GCI_BIT];
          end
        end
        `IFO_ADDR_MEAS: begin
          s_next.rdata = {16'h0000, meas};
        end
        `IFO_ADDR_STATUS: begin
          s_next.rdata = {16'h0000, s_reg.frames};
        end
        default: begin
          s_next.err = 1'b1;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg        <= '0;
      s_reg.ofs_lo <= `IFO_OFS_RESET;
      s_reg.ofs_hi <= `IFO_OFS_RESET;
      s_reg.fp_s   <= 2'b11;
      s_reg.fp_d   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // One lane per stream, group i of the active image
  generate
    for (genvar i = 0; i < NSTR; i++) begin : g_lane
      ifo_lane u_lane (
        .pclk        (pclk),
        .presetn     (presetn),
        .rise_evt    (rise_evt),
        .fall_evt    (fall_evt),
        .frame_evt   (frame_evt),
        .gci_mode    (s_reg.gci),
        .data_in     (st_now[i]),
        .grp         (s_reg.act[`IFO_GRP_W*i +: `IFO_GRP_W]),
        .bit_valid   (lv[i]),
        .bit_data    (ld[i]),
        .frame_start (lf[i])
      );
    end
  endgenerate

  assign prdata         = s_reg.rdata;
  assign pready         = s_reg.ready;
  assign pslverr        = s_reg.err;
  assign rx_valid       = s_reg.v;
  assign rx_data        = s_reg.d;
  assign rx_frame_start = s_reg.f;
endmodule

// [pkg/ifo_defines.svh]
`ifndef IFO_DEFINES_SVH
`define IFO_DEFINES_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
// Register indices; the byte address is four times the index
`define IFO_IDX_OFS_LO    12'h004
`define IFO_IDX_OFS_HI    12'h005
`define IFO_ADDR_OFS_LO   (`IFO_IDX_OFS_LO << 2)
`define IFO_ADDR_OFS_HI   (`IFO_IDX_OFS_HI << 2)
`define IFO_ADDR_CTRL     12'h018
`define IFO_ADDR_MEAS     12'h01c
`define IFO_ADDR_STATUS   12'h020
`define IFO_OFS_RESET     16'h0000
`define IFO_CTRL_GCI_BIT  0
`define IFO_GRP_W         4
`define IFO_EDGE_BIT      0
`define IFO_SHIFT_LSB     1
`define IFO_MAX_SHIFT     3'h4
`endif

// [pkg/ifo_pkg.sv]
package ifo_pkg;
  typedef enum logic [1:0] {
    IFO_IDLE = 2'b00,
    IFO_WAIT = 2'b01,
    IFO_RUN  = 2'b10
  } ifo_state_t;
endpackage

// [hdl/ifo_lane.sv]
`timescale 1ns/1ps
`include "ifo_defines.svh"
// ****************************************
// One stream lane: delay and sampling
// ****************************************
module ifo_lane (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Link events, already synchronised
  input  wire logic       rise_evt,
  input  wire logic       fall_evt,
  input  wire logic       frame_evt,
  input  wire logic       gci_mode,
  input  wire logic       data_in,
  // Active configuration group
  input  wire logic [3:0] grp,
  // Results
  output logic            bit_valid,
  output logic            bit_data,
  output logic            frame_start
);
  typedef struct packed {
    ifo_pkg::ifo_state_t st;
    logic [3:0]          half_cnt;
    logic                valid;
    logic                data;
    logic                fstart;
    logic                first;
  } ifo_lane_st_t;

  ifo_lane_st_t s_reg;
  ifo_lane_st_t s_next;
  logic         use_fall;
  logic         samp_evt;
  logic [3:0]   target;

  // Edge choice per mode
  always_comb begin
    if (gci_mode) begin
      use_fall = ~grp[`IFO_EDGE_BIT];
    end else begin
      use_fall = grp[`IFO_EDGE_BIT];
    end
    samp_evt = use_fall ? fall_evt : rise_evt;
    // Half periods to wait: shift bits doubled plus edge bit, shift capped at 4 (at most 9 half periods)
    target = {grp[3:1], 1'b0} + {3'h0, grp[`IFO_EDGE_BIT]};
    if (grp[3:1] > `IFO_MAX_SHIFT) begin
      target = {`IFO_MAX_SHIFT, grp[`IFO_EDGE_BIT]};
    end
  end

  // Frame delay state machine
  always_comb begin
    s_next        = s_reg;
    s_next.valid  = 1'b0;
    s_next.fstart = 1'b0;
    case (s_reg.st)
      ifo_pkg::IFO_IDLE: begin
        if (frame_evt) begin
          s_next.st       = ifo_pkg::IFO_WAIT;
          s_next.half_cnt = 4'h0;
        end
      end
      ifo_pkg::IFO_WAIT, ifo_pkg::IFO_RUN: begin
        if (frame_evt) begin
          s_next.st       = ifo_pkg::IFO_WAIT;
          s_next.half_cnt = 4'h0;
        end else if (s_reg.st == ifo_pkg::IFO_WAIT) begin
          if (rise_evt || fall_evt) begin
            s_next.half_cnt = s_reg.half_cnt + 4'h1;
          end
          if (s_reg.half_cnt >= target) begin
            s_next.st    = ifo_pkg::IFO_RUN;
            s_next.first = 1'b1;
          end
        end else if (samp_evt) begin
          s_next.valid  = 1'b1;
          s_next.data   = data_in;
          s_next.fstart = s_reg.first;
          s_next.first  = 1'b0;
        end
      end
      default: begin
        s_next.st = ifo_pkg::IFO_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bit_valid   = s_reg.valid;
  assign bit_data    = s_reg.data;
  assign frame_start = s_reg.fstart;
endmodule

// [dv/ifo_top_asserts.sv]
`timescale 1ns/1ps
// ****************************************
// Port checks for the offset block
// ****************************************
module ifo_top_asserts #(
  parameter int NSTR = 8
) (
  // APB side
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // Link side
  input wire logic            frame_pulse_in,
  input wire logic [NSTR-1:0] rx_valid,
  input wire logic [NSTR-1:0] rx_frame_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and its single-cycle answer
  sequence acc_s; psel && penable && !pready; endsequence
  sequence ans_s; pready ##1 !pready; endsequence
  access_answer_a: assert property (acc_s |=> ans_s)
    else $error("access not answered once");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("answer without access");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("error outside answer");
  mapped_ok_a: assert property (pready && paddr inside {12'h010, 12'h014, 12'h018,
    12'h01c, 12'h020} |-> !pslverr) else $error("error on mapped address");
  upper_zero_a: assert property (pready && !pwrite && paddr inside {12'h010, 12'h014}
    |-> prdata[31:16] == 16'h0000) else $error("offset upper half not zero");
  start_valid_a: assert property (|rx_frame_start |-> (rx_frame_start & ~rx_valid) == '0)
    else $error("frame start without bit");
  valid_pulse_a: assert property (|rx_valid |=> (rx_valid == '0)[*4])
    else $error("bits closer than one edge");
  frame_start_a: assert property ($fell(frame_pulse_in) |-> ##[3:90] rx_frame_start[0])
    else $error("no frame start after pulse");
endmodule

bind ifo_top ifo_top_asserts #(.NSTR(NSTR)) ifo_top_asserts_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_pulse_in(frame_pulse_in),
  .rx_valid(rx_valid), .rx_frame_start(rx_frame_start));

// [dv/ifo_link_model.sv]
`timescale 1ns/1ps
// ****************************************
// Serial source: bit clock, frame, streams
// ****************************************
module ifo_link_model (
  // Frame request
  input  wire logic [31:0] dly,
  input  wire logic [7:0]  first_bits,
  input  wire logic        go,
  // Link pins
  output logic             link_clk,
  output logic             frame_pulse_in,
  output logic [7:0]       serial_stream_in
);
  int hc;
  // One frame per request; clock stands high between frames
  initial begin
    link_clk = 1'b1;
    frame_pulse_in = 1'b1;
    serial_stream_in = 8'h00;
    forever begin
      @(posedge go);
      #1;
      for (hc = 0; hc < 24; hc++) begin
        link_clk = hc[0];
        frame_pulse_in = (hc > 1);
        for (int k = 0; k < 8; k++) begin
          // Bit 0 held around the shifted sample point only
          serial_stream_in[k] = (hc + 1 >= dly[4*k+:4] && hc <= dly[4*k+:4] + 1) ?
            first_bits[k] : !first_bits[k];
        end
        #24;
      end
      link_clk = 1'b1;
      frame_pulse_in = 1'b1;
      serial_stream_in = ~first_bits;
    end
  end
endmodule

// [dv/ifo_top_tb.sv]
`timescale 1ns/1ps
// ****************************************
// Bench for the offset block
// ****************************************
module ifo_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lclk, fpi, er, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, mdly;
  logic [7:0]  sin, rxv, rxd, rxs, fb, bs;
  int          ts [8];
  int          cyc, err_total, compares;
  ifo_top #(.NSTR(8)) ifo_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(lclk), .frame_pulse_in(fpi),
    .serial_stream_in(sin), .rx_valid(rxv), .rx_data(rxd), .rx_frame_start(rxs));
  ifo_link_model ifo_link_model_inst (.dly(mdly), .first_bits(fb), .go(go),
    .link_clk(lclk), .frame_pulse_in(fpi), .serial_stream_in(sin));
  // Clock
  always #2 pclk = ~pclk;
  // Frame start time and bit per stream
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 8; k++) if (rxs[k] === 1'b1) begin
      ts[k] <= cyc;
      bs[k] <= rxd[k];
    end
  end
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    cmp("rdata", e, rd);
    cmp("slverr", {31'h0, ee}, {31'h0, er});
  endtask
  // One frame; new offsets written after its pulse
  task run_frame(input logic [31:0] d, input logic [7:0] b, input bit chk, input logic [31:0] nw);
    mdly <= d; fb <= b; ts = '{default: 0}; go <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h010, {16'h0, nw[15:0]});
    apb(1'b1, 12'h014, {16'h0, nw[31:16]});
    repeat (140) @(posedge pclk); go <= 1'b0;
    @(posedge pclk);
    for (int k = 0; k < 8; k++) if (chk) begin
      cmp("seen", 1, ts[k] != 0);
      cmp("start", 6 * d[4*k+:4], ts[k] - ts[0]);
      cmp("bit", {31'h0, b[k]}, {31'h0, bs[k]});
    end else if (k % 2) cmp("gci", 1, ts[k] != 0);
    else cmp("gci", 1, ts[k] != 0);
  endtask
  task t_regs;
    rdchk(12'h014, 32'h0, 1'b0);
    apb(1'b1, 12'h010, 32'hffff_a5c3);
    apb(1'b1, 12'h014, 32'h0000_5a3c);
    rdchk(12'h010, 32'h0000_a5c3, 1'b0);
    rdchk(12'h014, 32'h0000_5a3c, 1'b0);
    rdchk(12'h0fc, 32'h0, 1'b1);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h014, 32'h0);
  endtask
  task t_frames;
    run_frame(32'h0, 8'h3c, 1, 32'h9654_3210);
    run_frame(32'h9654_3210, 8'ha5, 1, 32'h9654_3210);
    apb(1'b1, 12'h018, 32'h1);
    run_frame(32'h9654_3210, 8'h5a, 0, 32'h9654_3210);
  endtask
  task t_meas;
    logic [3:0] g;
    foreach (ts[i]) if (i < 3) begin
      g = (i == 0) ? 4'h0 : ((i == 1) ? 4'h3 : 4'h9);
      // New offsets become active only at the following frame pulse
      run_frame({28'h0, g}, 8'h00, 0, {28'h0, g});
      run_frame({28'h0, g}, 8'h00, 0, {28'h0, g});
      apb(1'b0, 12'h01c, 32'h0);
      cmp("meas", {20'h0, ~g[0], 8'h0, g[3:1]}, rd & 32'h807);
    end
  endtask
  task give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    go = 0; mdly = 0; fb = 0; cyc = 0; err_total = 0; compares = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_frames;
    t_meas;
    give_verdict;
  end
  // Watchdog
  initial begin
    #40000;
    err_total++;
    give_verdict;
  end
endmodule
